// File: rtl/pcso_decode.sv
// Opcode decoder with kernel level check
`timescale 1ns/1ns
`default_nettype none
module pcso_decode (
	input wire logic [15:0] opcode,
	input wire logic [31:0] psw,
	output pcso_pkg::pcso_op_e op,
	output logic kernel
);
	assign kernel = (psw[pcso_pkg::PSW_CM +: 2] == pcso_pkg::LVL_KERNEL); // [RQ1]
	always_comb begin
		case (opcode)
			pcso_pkg::OPC_CALL: op = pcso_pkg::OP_CALL; // [RQ2]
			pcso_pkg::OPC_RET: op = pcso_pkg::OP_RET;
			pcso_pkg::OPC_PJMP: op = pcso_pkg::OP_PJMP;
			pcso_pkg::OPC_VJMP: op = pcso_pkg::OP_VJMP;
			pcso_pkg::OPC_IACK: op = pcso_pkg::OP_IACK;
			pcso_pkg::OPC_WAIT: op = pcso_pkg::OP_WAIT;
			default: op = pcso_pkg::OP_NONE;
		endcase
	end
endmodule : pcso_decode
`default_nettype wire

// File: rtl/pcso_pkg.sv
// Constants, types and helpers for the privileged context switch sequencer
// Overview of operation
// (RQ1) Privileged group runs only at kernel level
// (RQ2) Opcode 30AC decodes as call process
// (RQ3) Push old pointer; fault gives stack reset
// (RQ4) New control block pointer comes from r0
// (RQ5) Load status, counter, stack from new block
// (RQ6) Save context if save flag; extras too
// (RQ7) Block moves only with save, no extras
// (RQ8) Old status gets 0/0/1, new 7/0/3
// (RQ9) Saved return address is instruction plus two
// (RQ10) Phase one faults old; later faults new
// (RQ11) Force kernel access throughout the switch
// (RQ12) 3013: pin high, jump r0, flush
// (RQ13) 300D: pin low, jump r0, flush
// (RQ14) Vectored acknowledge: identifier shifted two to r0
// (RQ15) Nonmaskable: all-ones acknowledge, r0 gets zero
// (RQ16) Autovector: inverted level on address bus
// (RQ17) 30C8 pops saved pointer, no context save
// (RQ18) Return reloads block, moves, restores registers
// (RQ19) Fixed register roles r9 through r15
// (RQ20) Word pushes and pops step by four
// (RQ21) Wait halts until interrupt or reset
// (RQ22) Return sets 7/0/3; pop fault resets
// (RQ23) Restore from offsets 20, 24, 28, 64
// (RQ24) Jump and flush land before next fetch
// (RQ25) No interrupts inside a switch sequence
package pcso_pkg;
	localparam logic [15:0] OPC_CALL = 16'h30AC;
	localparam logic [15:0] OPC_RET = 16'h30C8;
	localparam logic [15:0] OPC_PJMP = 16'h3013;
	localparam logic [15:0] OPC_VJMP = 16'h300D;
	localparam logic [15:0] OPC_IACK = 16'h302F;
	localparam logic [15:0] OPC_WAIT = 16'h002F;
	localparam logic [11:0] A_INSTR = 12'h000;
	localparam logic [11:0] A_STATUS = 12'h004;
	localparam logic [11:0] A_RIDX = 12'h008;
	localparam logic [11:0] A_RDATA = 12'h00C;
	localparam int PSW_XT = 0;
	localparam int PSW_TR = 2;
	localparam int PSW_SC = 3;
	localparam int PSW_CM = 11;
	localparam int PSW_R = 23;
	localparam int PSW_XR = 25;
	localparam logic [1:0] LVL_KERNEL = 2'h0;
	localparam logic [4:0] R_FRM = 5'h09;
	localparam logic [4:0] R_ARG = 5'h0A;
	localparam logic [4:0] R_PSW = 5'h0B;
	localparam logic [4:0] R_SP = 5'h0C;
	localparam logic [4:0] R_ISP = 5'h0D;
	localparam logic [4:0] R_PCBP = 5'h0E;
	localparam logic [4:0] R_PC = 5'h0F;
	localparam logic [4:0] R_EXT = 5'h10;
	localparam logic [31:0] OFF_CTX = 32'h0000_0014;
	localparam logic [31:0] OFF_EXT = 32'h0000_0040;
	localparam logic [31:0] OFF_BLK = 32'h0000_0040;
	localparam logic [31:0] STEP_W = 32'h0000_0004;
	localparam logic [31:0] STEP_NEXT = 32'h0000_0002;
	localparam logic [31:0] STEP_WAIT = 32'h0000_0001;
	localparam logic [31:0] IACK_ONES = 32'hFFFF_FFFF;
	localparam logic [4:0] BASE_N = 5'h03;
	localparam logic [4:0] CTX_N = 5'h0B;
	localparam logic [4:0] EXT_N = 5'h08;
	localparam logic [3:0] SC_OLD = 4'h0;
	localparam logic [1:0] XT_OLD = 2'h1;
	localparam logic [3:0] SC_NEW = 4'h7;
	localparam logic [1:0] XT_NEW = 2'h3;
	localparam logic [2:0] EXC_NONE = 3'h0;
	localparam logic [2:0] EXC_PRIV = 3'h1;
	localparam logic [2:0] EXC_RST_ISP = 3'h2;
	localparam logic [2:0] EXC_PROC_OLD = 3'h3;
	localparam logic [2:0] EXC_PROC_NEW = 3'h4;
	localparam logic [2:0] EXC_ILLEGAL = 3'h5;
	localparam int ST_BUSY = 0;
	localparam int ST_WAIT = 1;
	localparam int ST_VIRT = 2;
	localparam int ST_EXC = 4;
	typedef enum {OP_NONE, OP_CALL, OP_RET, OP_PJMP, OP_VJMP, OP_IACK, OP_WAIT} pcso_op_e;
	typedef enum {S_IDLE, S_PUSH, S_POP, S_RDPSW, S_SAVEB, S_SAVEC, S_SAVEX, S_LOADB,
		S_BLKC, S_BLKS, S_BLKD, S_BLKR, S_BLKW, S_RSTC, S_RSTX, S_IACK, S_WAIT} pcso_st_e;
	typedef struct packed {
		logic valid;
		logic write;
		logic iack;
		logic kernel;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pcso_req_s;
	typedef struct packed {
		logic ack;
		logic fault;
		logic [31:0] rdata;
	} pcso_rsp_s;
	// Register restored or saved at context slot k
	function automatic logic [4:0] ctx_reg(input logic [4:0] k);
		ctx_reg = (k == 5'h00) ? R_ARG : (k == 5'h01) ? R_FRM : 5'(k - 5'h02); // [RQ19]
	endfunction : ctx_reg
	// Replace state code, trace mask and execution type
	function automatic logic [31:0] set_ste(input logic [31:0] psw, input logic [3:0] sc,
		input logic [1:0] xt);
		set_ste = psw;
		set_ste[PSW_SC +: 4] = sc;
		set_ste[PSW_TR] = 1'b0;
		set_ste[PSW_XT +: 2] = xt;
	endfunction : set_ste
endpackage : pcso_pkg

// File: rtl/pcso_regfile.sv
// General register array with r0 tap
`timescale 1ns/1ns
`default_nettype none
module pcso_regfile (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [31:0] wdata,
	input wire logic [4:0] raddr,
	output logic [31:0] rdata,
	output logic [31:0] r0
);
	logic [31:0] regs_q [32];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 32; i++) begin
				regs_q[i] <= 32'h0000_0000;
			end
		end else if (we) begin
			regs_q[waddr] <= wdata;
		end
	end
	assign rdata = regs_q[raddr];
	assign r0 = regs_q[0];
endmodule : pcso_regfile
`default_nettype wire

// File: rtl/pcso_top.sv
// Privileged context switch sequencer with APB control port
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pcso_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output var pcso_pkg::pcso_req_s mem_req,
	input wire pcso_pkg::pcso_rsp_s mem_rsp,
	input wire logic nonmaskable_interrupt_input_n,
	input wire logic autovector_input_n,
	input wire logic irq_n,
	input wire logic [3:0] irq_level,
	output logic virtual_address_pin_n,
	output logic icache_flush,
	output logic exc_event
);
	pcso_pkg::pcso_st_e st_q;
	pcso_pkg::pcso_op_e op_q, dec_op;
	logic [31:0] psw_q, pc_q, sp_q, isp_q, pcbp_q, newpcb_q, tmp_q;
	logic [31:0] ptr_q, src_q, dst_q, cnt_q;
	logic new_r_q, new_xr_q, dec_kernel;
	logic [4:0] k_q, ridx_q;
	logic [15:0] opc_q;
	logic [2:0] exc_q;
	logic [6:0] s1_q, s2_q, s3_q, pin_q;
	logic [31:0] r0_val, rf_rdata, acc_addr, acc_wdata, reg_view;
	logic [4:0] rf_raddr, rf_waddr;
	logic [31:0] rf_wdata;
	logic rf_we, acc_wr, apb_acc, apb_wr, apb_err, ack, mem_st;
	logic issue, nmi, avin, irq;

	pcso_decode u_dec (
		.opcode(pwdata[15:0]),
		.psw(psw_q),
		.op(dec_op),
		.kernel(dec_kernel)
	);
	pcso_regfile u_rf (
		.pclk(pclk),
		.presetn(presetn),
		.we(rf_we),
		.waddr(rf_waddr),
		.wdata(rf_wdata),
		.raddr(rf_raddr),
		.rdata(rf_rdata),
		.r0(r0_val)
	);

	// Pin inputs: three stages, accepted when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 7'h07;
			s2_q <= 7'h07;
			s3_q <= 7'h07;
			pin_q <= 7'h07;
		end else begin
			s1_q <= {irq_level, irq_n, autovector_input_n, nonmaskable_interrupt_input_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
		end
	end
	assign nmi = !pin_q[0];
	assign avin = !pin_q[1];
	assign irq = !pin_q[2];

	// APB decode
	assign apb_acc = psel && penable && pready;
	assign apb_wr = apb_acc && pwrite && !pslverr;
	assign issue = apb_wr && (paddr[11:0] == pcso_pkg::A_INSTR);
	always_comb begin
		case (ridx_q)
			pcso_pkg::R_PSW: reg_view = psw_q;
			pcso_pkg::R_SP: reg_view = sp_q;
			pcso_pkg::R_ISP: reg_view = isp_q;
			pcso_pkg::R_PCBP: reg_view = pcbp_q;
			pcso_pkg::R_PC: reg_view = pc_q;
			default: reg_view = rf_rdata;
		endcase
	end
	always_comb begin
		case (paddr[11:0])
			pcso_pkg::A_INSTR, pcso_pkg::A_RDATA: apb_err = pwrite && (st_q != pcso_pkg::S_IDLE);
			pcso_pkg::A_STATUS: apb_err = pwrite;
			pcso_pkg::A_RIDX: apb_err = 1'b0;
			default: apb_err = 1'b1;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= apb_err;
			case (paddr[11:0])
				pcso_pkg::A_INSTR: prdata <= {16'h0000, opc_q};
				pcso_pkg::A_STATUS: prdata <= {25'h0, exc_q, 1'b0, !virtual_address_pin_n,
					st_q == pcso_pkg::S_WAIT, st_q != pcso_pkg::S_IDLE};
				pcso_pkg::A_RIDX: prdata <= {27'h0, ridx_q};
				pcso_pkg::A_RDATA: prdata <= reg_view;
				default: prdata <= 32'h0000_0000;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ridx_q <= 5'h00;
		end else if (apb_wr && paddr[11:0] == pcso_pkg::A_RIDX) begin
			ridx_q <= pwdata[4:0];
		end
	end

	// Memory access wanted by each sequencer state
	always_comb begin
		acc_wr = 1'b0;
		acc_addr = 32'h0000_0000;
		acc_wdata = 32'h0000_0000;
		rf_raddr = ridx_q;
		mem_st = 1'b1;
		case (st_q)
			pcso_pkg::S_PUSH: begin
				acc_wr = 1'b1;
				acc_addr = isp_q;
				acc_wdata = pcbp_q; // [RQ3]
			end
			pcso_pkg::S_POP: acc_addr = isp_q - pcso_pkg::STEP_W; // [RQ17] [RQ20]
			pcso_pkg::S_RDPSW: acc_addr = newpcb_q;
			pcso_pkg::S_SAVEB: begin
				acc_wr = 1'b1;
				acc_addr = pcbp_q + {25'h0, k_q, 2'b00};
				acc_wdata = (k_q == 5'h00) ? psw_q : (k_q == 5'h01) ? pc_q : sp_q;
			end
			pcso_pkg::S_SAVEC: begin
				acc_wr = 1'b1;
				rf_raddr = pcso_pkg::ctx_reg(k_q);
				acc_addr = pcbp_q + pcso_pkg::OFF_CTX + {25'h0, k_q, 2'b00};
				acc_wdata = rf_rdata; // [RQ6]
			end
			pcso_pkg::S_SAVEX: begin
				acc_wr = 1'b1;
				rf_raddr = pcso_pkg::R_EXT + k_q;
				acc_addr = pcbp_q + pcso_pkg::OFF_EXT + {25'h0, k_q, 2'b00};
				acc_wdata = rf_rdata; // [RQ6]
			end
			pcso_pkg::S_LOADB: acc_addr = pcbp_q + {25'h0, k_q, 2'b00}; // [RQ5]
			pcso_pkg::S_BLKC, pcso_pkg::S_BLKS, pcso_pkg::S_BLKD: acc_addr = ptr_q;
			pcso_pkg::S_BLKR: acc_addr = src_q;
			pcso_pkg::S_BLKW: begin
				acc_wr = 1'b1;
				acc_addr = dst_q;
				acc_wdata = tmp_q;
			end
			pcso_pkg::S_RSTC: acc_addr = pcbp_q + pcso_pkg::OFF_CTX + {25'h0, k_q, 2'b00}; // [RQ23]
			pcso_pkg::S_RSTX: acc_addr = pcbp_q + pcso_pkg::OFF_EXT + {25'h0, k_q, 2'b00}; // [RQ23]
			pcso_pkg::S_IACK: begin
				if (nmi || avin) begin
					acc_addr = nmi ? pcso_pkg::IACK_ONES : {28'hFFFFFFF, ~pin_q[6:3]}; // [RQ15] [RQ16]
				end
			end
			default: mem_st = 1'b0;
		endcase
	end
	assign ack = mem_req.valid && mem_rsp.ack;

	// Memory request, held until acknowledged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req <= '0;
		end else if (ack) begin
			mem_req.valid <= 1'b0;
		end else if (mem_st && !mem_req.valid) begin
			mem_req.valid <= 1'b1;
			mem_req.write <= acc_wr;
			mem_req.iack <= (st_q == pcso_pkg::S_IACK);
			mem_req.kernel <= (st_q != pcso_pkg::S_IACK); // [RQ11]
			mem_req.addr <= acc_addr;
			mem_req.wdata <= acc_wdata;
		end
	end

	// Register file write port: sequencer restores, acknowledge result to r0, or APB
	always_comb begin
		rf_we = 1'b0;
		rf_waddr = ridx_q;
		rf_wdata = pwdata;
		if (ack && !mem_rsp.fault && st_q == pcso_pkg::S_RSTC) begin
			rf_we = 1'b1;
			rf_waddr = pcso_pkg::ctx_reg(k_q); // [RQ18]
			rf_wdata = mem_rsp.rdata;
		end else if (ack && !mem_rsp.fault && st_q == pcso_pkg::S_RSTX) begin
			rf_we = 1'b1;
			rf_waddr = pcso_pkg::R_EXT + k_q;
			rf_wdata = mem_rsp.rdata;
		end else if (ack && !mem_rsp.fault && st_q == pcso_pkg::S_IACK) begin
			rf_we = 1'b1;
			rf_waddr = 5'h00;
			rf_wdata = nmi ? 32'h0000_0000 : {22'h0, mem_rsp.rdata[7:0], 2'b00}; // [RQ14] [RQ15]
		end else if (apb_wr && paddr[11:0] == pcso_pkg::A_RDATA && (ridx_q < pcso_pkg::R_PSW
			|| ridx_q > pcso_pkg::R_PC)) begin
			rf_we = 1'b1;
		end
	end

	// Sequencer; interrupts are only looked at in the wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= pcso_pkg::S_IDLE;
			op_q <= pcso_pkg::OP_NONE;
			psw_q <= 32'h0000_0000;
			pc_q <= 32'h0000_0000;
			sp_q <= 32'h0000_0000;
			isp_q <= 32'h0000_0000;
			pcbp_q <= 32'h0000_0000;
			newpcb_q <= 32'h0000_0000;
			tmp_q <= 32'h0000_0000;
			ptr_q <= 32'h0000_0000;
			src_q <= 32'h0000_0000;
			dst_q <= 32'h0000_0000;
			cnt_q <= 32'h0000_0000;
			new_r_q <= 1'b0;
			new_xr_q <= 1'b0;
			k_q <= 5'h00;
			opc_q <= 16'h0000;
			exc_q <= pcso_pkg::EXC_NONE;
			exc_event <= 1'b0;
			icache_flush <= 1'b0;
			virtual_address_pin_n <= 1'b1;
		end else begin
			exc_event <= 1'b0;
			icache_flush <= 1'b0;
			if (ack && mem_rsp.fault) begin
				st_q <= pcso_pkg::S_IDLE;
				exc_event <= 1'b1;
				case (st_q)
					pcso_pkg::S_PUSH, pcso_pkg::S_POP: exc_q <= pcso_pkg::EXC_RST_ISP; // [RQ3] [RQ22]
					pcso_pkg::S_RDPSW, pcso_pkg::S_SAVEB, pcso_pkg::S_SAVEC,
					pcso_pkg::S_SAVEX: exc_q <= pcso_pkg::EXC_PROC_OLD; // [RQ10]
					pcso_pkg::S_IACK: exc_q <= pcso_pkg::EXC_ILLEGAL;
					default: exc_q <= pcso_pkg::EXC_PROC_NEW; // [RQ10]
				endcase
			end else begin
				case (st_q)
					pcso_pkg::S_IDLE: begin
						if (issue) begin
							opc_q <= pwdata[15:0];
							exc_q <= pcso_pkg::EXC_NONE;
							op_q <= dec_op;
							k_q <= 5'h00;
							if (dec_op == pcso_pkg::OP_NONE) begin
								exc_q <= pcso_pkg::EXC_ILLEGAL;
								exc_event <= 1'b1;
							end else if (!dec_kernel) begin
								exc_q <= pcso_pkg::EXC_PRIV; // [RQ1]
								exc_event <= 1'b1;
							end else begin
								case (dec_op)
									pcso_pkg::OP_CALL: begin
										newpcb_q <= r0_val; // [RQ4]
										st_q <= pcso_pkg::S_PUSH;
									end
									pcso_pkg::OP_RET: st_q <= pcso_pkg::S_POP;
									pcso_pkg::OP_PJMP, pcso_pkg::OP_VJMP: begin
										virtual_address_pin_n <= (dec_op == pcso_pkg::OP_PJMP); // [RQ12] [RQ13]
										pc_q <= r0_val; // [RQ24]
										icache_flush <= 1'b1;
									end
									pcso_pkg::OP_IACK: st_q <= pcso_pkg::S_IACK;
									pcso_pkg::OP_WAIT: st_q <= pcso_pkg::S_WAIT; // [RQ21]
									default: st_q <= pcso_pkg::S_IDLE;
								endcase
							end
						end else if (apb_wr && paddr[11:0] == pcso_pkg::A_RDATA) begin
							case (ridx_q)
								pcso_pkg::R_PSW: psw_q <= pwdata;
								pcso_pkg::R_SP: sp_q <= pwdata;
								pcso_pkg::R_ISP: isp_q <= pwdata;
								pcso_pkg::R_PCBP: pcbp_q <= pwdata;
								pcso_pkg::R_PC: pc_q <= pwdata;
								default: ;
							endcase
						end
					end
					pcso_pkg::S_PUSH: if (ack) begin
						isp_q <= isp_q + pcso_pkg::STEP_W; // [RQ20]
						pc_q <= pc_q + pcso_pkg::STEP_NEXT; // [RQ9]
						psw_q <= pcso_pkg::set_ste(psw_q, pcso_pkg::SC_OLD, pcso_pkg::XT_OLD); // [RQ8]
						st_q <= pcso_pkg::S_RDPSW;
					end
					pcso_pkg::S_POP: if (ack) begin
						isp_q <= isp_q - pcso_pkg::STEP_W;
						newpcb_q <= mem_rsp.rdata; // [RQ17]
						st_q <= pcso_pkg::S_RDPSW;
					end
					pcso_pkg::S_RDPSW: if (ack) begin
						new_r_q <= mem_rsp.rdata[pcso_pkg::PSW_R];
						new_xr_q <= mem_rsp.rdata[pcso_pkg::PSW_XR];
						if (op_q == pcso_pkg::OP_CALL) begin
							st_q <= pcso_pkg::S_SAVEB;
						end else begin
							pcbp_q <= newpcb_q;
							st_q <= pcso_pkg::S_LOADB;
						end
					end
					pcso_pkg::S_SAVEB: if (ack) begin
						k_q <= k_q + 5'h01;
						if (k_q == pcso_pkg::BASE_N - 5'h01) begin
							k_q <= 5'h00;
							if (new_r_q) begin
								st_q <= pcso_pkg::S_SAVEC;
							end else if (new_xr_q) begin
								st_q <= pcso_pkg::S_SAVEX;
							end else begin
								pcbp_q <= newpcb_q;
								st_q <= pcso_pkg::S_LOADB;
							end
						end
					end
					pcso_pkg::S_SAVEC, pcso_pkg::S_SAVEX: if (ack) begin
						k_q <= k_q + 5'h01;
						if (st_q == pcso_pkg::S_SAVEC && k_q == pcso_pkg::CTX_N - 5'h01) begin
							k_q <= 5'h00;
							if (new_xr_q) begin
								st_q <= pcso_pkg::S_SAVEX; // [RQ6]
							end else begin
								pcbp_q <= newpcb_q;
								st_q <= pcso_pkg::S_LOADB;
							end
						end else if (st_q == pcso_pkg::S_SAVEX && k_q == pcso_pkg::EXT_N - 5'h01) begin
							k_q <= 5'h00;
							pcbp_q <= newpcb_q; // [RQ4]
							st_q <= pcso_pkg::S_LOADB;
						end
					end
					pcso_pkg::S_LOADB: if (ack) begin
						k_q <= k_q + 5'h01;
						case (k_q)
							5'h00: psw_q <= mem_rsp.rdata;
							5'h01: pc_q <= mem_rsp.rdata;
							default: sp_q <= mem_rsp.rdata;
						endcase
						if (k_q == pcso_pkg::BASE_N - 5'h01) begin
							k_q <= 5'h00;
							psw_q <= pcso_pkg::set_ste(psw_q, pcso_pkg::SC_NEW, pcso_pkg::XT_NEW); // [RQ8] [RQ22]
							ptr_q <= pcbp_q + pcso_pkg::OFF_BLK;
							if (psw_q[pcso_pkg::PSW_R] && !psw_q[pcso_pkg::PSW_XR]) begin
								st_q <= pcso_pkg::S_BLKC; // [RQ7]
							end else if (op_q == pcso_pkg::OP_RET && psw_q[pcso_pkg::PSW_R]) begin
								st_q <= pcso_pkg::S_RSTC;
							end else begin
								st_q <= pcso_pkg::S_IDLE;
							end
						end
					end
					pcso_pkg::S_BLKC: if (ack) begin
						cnt_q <= mem_rsp.rdata;
						ptr_q <= ptr_q + pcso_pkg::STEP_W;
						if (mem_rsp.rdata != 32'h0000_0000) begin
							st_q <= pcso_pkg::S_BLKS;
						end else if (op_q == pcso_pkg::OP_RET) begin
							st_q <= pcso_pkg::S_RSTC; // [RQ18]
						end else begin
							st_q <= pcso_pkg::S_IDLE;
						end
					end
					pcso_pkg::S_BLKS: if (ack) begin
						src_q <= mem_rsp.rdata;
						ptr_q <= ptr_q + pcso_pkg::STEP_W;
						st_q <= pcso_pkg::S_BLKD;
					end
					pcso_pkg::S_BLKD: if (ack) begin
						dst_q <= mem_rsp.rdata;
						ptr_q <= ptr_q + pcso_pkg::STEP_W;
						st_q <= pcso_pkg::S_BLKR;
					end
					pcso_pkg::S_BLKR: if (ack) begin
						tmp_q <= mem_rsp.rdata;
						src_q <= src_q + pcso_pkg::STEP_W;
						st_q <= pcso_pkg::S_BLKW;
					end
					pcso_pkg::S_BLKW: if (ack) begin
						dst_q <= dst_q + pcso_pkg::STEP_W;
						cnt_q <= cnt_q - 32'h0000_0001;
						st_q <= (cnt_q == 32'h0000_0001) ? pcso_pkg::S_BLKC : pcso_pkg::S_BLKR;
					end
					pcso_pkg::S_RSTC: if (ack) begin
						k_q <= k_q + 5'h01;
						if (k_q == pcso_pkg::CTX_N - 5'h01) begin
							k_q <= 5'h00;
							st_q <= psw_q[pcso_pkg::PSW_XR] ? pcso_pkg::S_RSTX : pcso_pkg::S_IDLE; // [RQ18]
						end
					end
					pcso_pkg::S_RSTX: if (ack) begin
						k_q <= k_q + 5'h01;
						if (k_q == pcso_pkg::EXT_N - 5'h01) begin
							k_q <= 5'h00;
							st_q <= pcso_pkg::S_IDLE;
						end
					end
					pcso_pkg::S_IACK: if (ack) begin
						st_q <= pcso_pkg::S_IDLE;
					end
					pcso_pkg::S_WAIT: if (irq) begin
						pc_q <= pc_q + pcso_pkg::STEP_WAIT; // [RQ21] [RQ25]
						st_q <= pcso_pkg::S_IDLE;
					end
					default: st_q <= pcso_pkg::S_IDLE;
				endcase
			end
		end
	end
endmodule : pcso_top
`default_nettype wire

// File: verif/pcso_mem_model.sv
// Memory, translation unit and interrupter model for the sequencer
`timescale 1ns/1ns
`default_nettype none
module pcso_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire pcso_pkg::pcso_req_s mem_req,
	output pcso_pkg::pcso_rsp_s mem_rsp,
	input wire logic [3:0] lat,
	input wire logic [31:0] fault_addr,
	input wire logic [7:0] vec_id
);
	logic [31:0] mem [0:1023];
	logic [3:0] cnt_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
			mem_rsp <= '0;
		end else if (mem_req.valid && !mem_rsp.ack && cnt_q >= lat) begin
			cnt_q <= 4'h0;
			mem_rsp.ack <= 1'b1;
			mem_rsp.fault <= (mem_req.addr === fault_addr);
			if (mem_req.iack) begin
				mem_rsp.rdata <= {24'hFFFFFF, vec_id};
			end else begin
				mem_rsp.rdata <= mem[mem_req.addr[11:2]];
			end
			if (mem_req.write && mem_req.addr !== fault_addr) begin
				mem[mem_req.addr[11:2]] <= mem_req.wdata;
			end
		end else begin
			cnt_q <= mem_req.valid ? cnt_q + 4'h1 : 4'h0;
			mem_rsp.ack <= 1'b0;
			mem_rsp.fault <= 1'b0;
			mem_rsp.rdata <= ~mem_rsp.rdata;
		end
	end
endmodule : pcso_mem_model
`default_nettype wire

// File: verif/pcso_top_asserts.sv
// Checker on the sequencer's memory, pin and flush ports
`timescale 1ns/1ns
`default_nettype none
module pcso_top_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire pcso_pkg::pcso_req_s mem_req,
	input wire pcso_pkg::pcso_rsp_s mem_rsp,
	input wire logic nonmaskable_interrupt_input_n,
	input wire logic autovector_input_n,
	input wire logic [3:0] irq_level,
	input wire logic virtual_address_pin_n,
	input wire logic icache_flush,
	input wire logic exc_event
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_nmi_held;
		!nonmaskable_interrupt_input_n [*8];
	endsequence
	sequence s_avin_held;
		(nonmaskable_interrupt_input_n && !autovector_input_n && $stable(irq_level)) [*8];
	endsequence
	sequence s_ack_req;
		mem_req.valid && mem_req.iack;
	endsequence
	a_nmi_ones: assert property (s_nmi_held ##0 s_ack_req |-> mem_req.addr == 32'hFFFFFFFF)
		else $error("nmi acknowledge address wrong");
	a_autovector_input_level: assert property (s_avin_held ##0 s_ack_req |->
		mem_req.addr == {28'hFFFFFFF, ~irq_level})
		else $error("autovector address wrong");
	a_iack_read: assert property (s_ack_req |-> !mem_req.write && !mem_req.kernel)
		else $error("acknowledge cycle kind wrong");
	a_force_kernel: assert property (mem_req.valid && !mem_req.iack |-> mem_req.kernel)
		else $error("memory cycle not forced kernel");
	a_phys_flush: assert property ($rose(virtual_address_pin_n) |-> icache_flush)
		else $error("physical switch without flush");
	a_virt_flush: assert property ($fell(virtual_address_pin_n) |-> icache_flush)
		else $error("virtual switch without flush");
	a_flush_pulse: assert property (icache_flush |-> !mem_req.valid ##1 !icache_flush)
		else $error("flush overlaps fetch");
	a_req_hold: assert property (mem_req.valid && !mem_rsp.ack |=>
		mem_req.valid && $stable(mem_req.addr))
		else $error("request dropped before ack");
	a_fault_abort: assert property (mem_req.valid && mem_rsp.ack && mem_rsp.fault |->
		##[1:4] exc_event)
		else $error("fault not posted");
endmodule : pcso_top_asserts
bind pcso_top pcso_top_asserts u_pcso_top_asserts (.pclk, .presetn, .mem_req, .mem_rsp,
	.nonmaskable_interrupt_input_n, .autovector_input_n, .irq_level,
	.virtual_address_pin_n, .icache_flush, .exc_event);
`default_nettype wire

// File: verif/tb_privileged_context_switch_ops.sv
// Self-checking bench for the privileged context switch sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_privileged_context_switch_ops;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic nmi_n, avin_n, irq_n, vap_n, flush, exc;
	logic [31:0] paddr, pwdata, prdata, fault_addr, rd;
	logic [3:0] irq_level, lat;
	logic [7:0] vec_id;
	pcso_pkg::pcso_req_s mem_req;
	pcso_pkg::pcso_rsp_s mem_rsp;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_flush = 0;
	pcso_top u_pcso_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp),
		.nonmaskable_interrupt_input_n(nmi_n), .autovector_input_n(avin_n), .irq_n(irq_n),
		.irq_level(irq_level), .virtual_address_pin_n(vap_n), .icache_flush(flush),
		.exc_event(exc));
	pcso_mem_model u_pcso_mem_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
		.mem_rsp(mem_rsp), .lat(lat), .fault_addr(fault_addr), .vec_id(vec_id));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (flush === 1'b1) n_flush++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {20'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wreg(input logic [4:0] i, input logic [31:0] v);
		apb(1'b1, pcso_pkg::A_RIDX, {27'h0, i});
		apb(1'b1, pcso_pkg::A_RDATA, v);
	endtask : wreg
	task automatic rreg(input logic [4:0] i, input logic [31:0] exp);
		apb(1'b1, pcso_pkg::A_RIDX, {27'h0, i});
		apb(1'b0, pcso_pkg::A_RDATA, 32'h0);
		chk(rd, exp);
	endtask : rreg
	task automatic run(input logic [15:0] op, input logic [2:0] code);
		apb(1'b1, pcso_pkg::A_INSTR, {16'h0, op});
		do apb(1'b0, pcso_pkg::A_STATUS, 32'h0); while (rd[0] !== 1'b0);
		chk({29'h0, rd[6:4]}, {29'h0, code});
	endtask : run
	task automatic t_priv();
		logic [15:0] ops [6];
		ops = '{pcso_pkg::OPC_CALL, pcso_pkg::OPC_RET, pcso_pkg::OPC_PJMP,
			pcso_pkg::OPC_VJMP, pcso_pkg::OPC_IACK, pcso_pkg::OPC_WAIT};
		wreg(pcso_pkg::R_PSW, 32'h0000_0800);
		foreach (ops[k]) run(ops[k], pcso_pkg::EXC_PRIV);
		chk(n_flush, 0);
		wreg(pcso_pkg::R_PSW, 32'h0);
		run(16'h1234, pcso_pkg::EXC_ILLEGAL);
		apb(1'b0, 12'h010, 32'h0);
		chk(err, 1);
	endtask : t_priv
	task automatic t_iack();
		vec_id <= 8'hA5;
		run(pcso_pkg::OPC_IACK, pcso_pkg::EXC_NONE);
		rreg(5'h00, 32'h0000_0294);
		nmi_n <= 1'b0;
		repeat (10) @(posedge pclk);
		run(pcso_pkg::OPC_IACK, pcso_pkg::EXC_NONE);
		rreg(5'h00, 32'h0);
		nmi_n <= 1'b1;
		avin_n <= 1'b0;
		irq_level <= 4'h5;
		repeat (10) @(posedge pclk);
		run(pcso_pkg::OPC_IACK, pcso_pkg::EXC_NONE);
		avin_n <= 1'b1;
	endtask : t_iack
	task automatic t_jumps();
		wreg(5'h00, 32'h0000_0100);
		run(pcso_pkg::OPC_VJMP, pcso_pkg::EXC_NONE);
		chk(vap_n, 0);
		rreg(pcso_pkg::R_PC, 32'h0000_0100);
		apb(1'b1, pcso_pkg::A_INSTR, {16'h0, pcso_pkg::OPC_WAIT});
		apb(1'b0, pcso_pkg::A_STATUS, 32'h0);
		chk(rd[1], 1);
		irq_n <= 1'b0;
		repeat (6) @(posedge pclk);
		apb(1'b0, pcso_pkg::A_STATUS, 32'h0);
		chk(rd[1], 0);
		irq_n <= 1'b1;
		rreg(pcso_pkg::R_PC, 32'h0000_0101);
		run(pcso_pkg::OPC_PJMP, pcso_pkg::EXC_NONE);
		chk(vap_n, 1);
		chk(n_flush, 2);
	endtask : t_jumps
	task automatic t_switch();
		u_pcso_mem_model.mem[10'h040] = 32'hDEAD_BEEF;
		u_pcso_mem_model.mem[10'h080] = 32'h0080_0000;
		u_pcso_mem_model.mem[10'h090] = 32'h0;
		u_pcso_mem_model.mem[10'h081] = 32'h0000_0400;
		u_pcso_mem_model.mem[10'h082] = 32'h0000_0800;
		lat <= 4'h3;
		wreg(pcso_pkg::R_ISP, 32'h0000_0100);
		wreg(5'h00, 32'h0000_0200);
		run(pcso_pkg::OPC_CALL, pcso_pkg::EXC_NONE);
		chk(u_pcso_mem_model.mem[10'h040], 32'h0);
		chk(u_pcso_mem_model.mem[10'h007], 32'h0000_0200);
		chk(u_pcso_mem_model.mem[10'h000], 32'h1);
		chk(u_pcso_mem_model.mem[10'h001], 32'h0000_0102);
		rreg(pcso_pkg::R_PCBP, 32'h0000_0200);
		rreg(pcso_pkg::R_ISP, 32'h0000_0104);
		rreg(pcso_pkg::R_PSW, 32'h0080_003B);
		rreg(pcso_pkg::R_PC, 32'h0000_0400);
		rreg(pcso_pkg::R_SP, 32'h0000_0800);
		lat <= 4'h0;
		run(pcso_pkg::OPC_RET, pcso_pkg::EXC_NONE);
		rreg(pcso_pkg::R_PCBP, 32'h0);
		rreg(pcso_pkg::R_ISP, 32'h0000_0100);
		rreg(pcso_pkg::R_PC, 32'h0000_0102);
		rreg(pcso_pkg::R_PSW, 32'h0000_003B);
	endtask : t_switch
	task automatic t_faults();
		logic [31:0] fa [3];
		logic [2:0] ec [3];
		fa = '{32'h0000_0100, 32'h0, 32'h0000_0204};
		ec = '{pcso_pkg::EXC_RST_ISP, pcso_pkg::EXC_PROC_OLD, pcso_pkg::EXC_PROC_NEW};
		foreach (fa[k]) begin
			fault_addr <= fa[k];
			wreg(pcso_pkg::R_ISP, 32'h0000_0100);
			wreg(5'h00, 32'h0000_0200);
			run(pcso_pkg::OPC_CALL, ec[k]);
		end
	endtask : t_faults
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		nmi_n = 1'b1;
		avin_n = 1'b1;
		irq_n = 1'b1;
		irq_level = 4'h0;
		lat = 4'h1;
		fault_addr = 32'h0000_0FF0;
		vec_id = 8'h00;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_priv();
		t_iack();
		t_jumps();
		t_switch();
		t_faults();
		wrap_up();
	end
endmodule : tb_privileged_context_switch_ops
`default_nettype wire
